/* pkg/irq_cfg.svh */
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

`define CLK_PERIOD_NS 10
`define REG_RELEASE_NS 2000
`define ACK_RELEASE_NS 500
`define REG_RELEASE_CYC (`REG_RELEASE_NS / `CLK_PERIOD_NS)
`define ACK_RELEASE_CYC (`ACK_RELEASE_NS / `CLK_PERIOD_NS)

`define DATA_W 32
`define MASK_BYTE 32'h0000_00FF
`define MASK_HALF 32'h0000_FFFF
`define MASK_WORD 32'hFFFF_FFFF

`define IRQ_LO 1
`define IRQ_HI 7

`define SY_IACKIN 0
`define SY_DS0 1
`define SY_DS1 2
`define SY_LWORD 3
`define SY_SLOT1 4
`define SY_ADDR_LO 5
`define SY_ADDR_HI 7
`define SY_WIDTH 8
`define SY_RESET 8'hEF

`endif

/* pkg/irq_pkg.sv */
`default_nettype none
package irq_pkg;

    typedef enum logic [1:0] {
        WIDTH_BYTE = 2'b00,
        WIDTH_HALF = 2'b01,
        WIDTH_WORD = 2'b10
    } status_width_t;

    typedef enum logic {
        REL_REGISTER = 1'b0,
        REL_ACK = 1'b1
    } release_mode_t;

    typedef enum logic [2:0] {
        ACK_IDLE = 3'b000,
        ACK_PASS = 3'b001,
        ACK_WAIT_DS = 3'b010,
        ACK_DRIVE = 3'b011,
        ACK_DTACK = 3'b100,
        ACK_WAIT_END = 3'b101
    } ack_state_t;

    typedef enum logic [1:0] {
        CD_IDLE = 2'b00,
        CD_WAIT_DS = 2'b01,
        CD_DRIVE = 2'b10
    } chain_state_t;

    typedef struct packed {
        chain_state_t state;
        logic out_n;
    } chain_reg_t;

    typedef struct packed {
        ack_state_t state;
        logic pending;
        logic armed;
        logic ds_prev;
        logic chain_prev;
        logic iackout_n;
        logic dtack_oe;
        logic [31:0] data;
        logic [31:0] data_oe;
        logic [7:1] irq_oe;
    } intr_reg_t;

endpackage
`default_nettype wire

/* verif/handler_model.sv */
`default_nettype none
module handler_model (
    input wire logic i_core_clk,
    input wire logic i_dtack_oe,
    input wire logic i_iack_first,
    output logic o_iack_n,
    output logic o_ds0_n,
    output logic o_ds1_n,
    output logic o_lword_n,
    output logic [3:1] o_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    time ds_fall_t;
    initial begin
        o_iack_n = 1'b1;
        o_ds0_n = 1'b1;
        o_ds1_n = 1'b1;
        o_lword_n = 1'b1;
        o_addr = 3'h0;
        ds_fall_t = 0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Acknowledge cycle; w: 0 byte, 1 halfword, 2 word; gap = cycles between the IACK and strobe falls
    task automatic ack_cycle(input logic [2:0] lvl, input int w, input int gap);
        int n;
        @(negedge i_core_clk);
        o_addr = lvl;
        o_lword_n = (w != 2);
        // Beyond slot one IACKIN only falls once DS0 is low
        if (i_iack_first) begin
            o_iack_n = 1'b0;
            repeat (gap) @(negedge i_core_clk);
        end
        o_ds0_n = 1'b0;
        o_ds1_n = (w == 0);
        ds_fall_t = $time;
        if (!i_iack_first) begin
            repeat (gap) @(negedge i_core_clk);
            o_iack_n = 1'b0;
        end
        n = 0;
        // Bus timeout when nobody answers
        while (i_dtack_oe !== 1'b1 && n < 30) begin
            @(posedge i_core_clk);
            n++;
        end
        @(negedge i_core_clk);
        o_ds0_n = 1'b1;
        o_ds1_n = 1'b1;
        o_lword_n = 1'b1;
        repeat (2) @(negedge i_core_clk);
        o_iack_n = 1'b1;
        // Released address lines show no stale value
        o_addr = ~o_addr;
        repeat (6) @(negedge i_core_clk);
    endtask
    // Strobe of a plain register access
    task automatic strobe(input int hold);
        @(negedge i_core_clk);
        o_ds0_n = 1'b0;
        repeat (hold) @(negedge i_core_clk);
        o_ds0_n = 1'b1;
        repeat (2) @(negedge i_core_clk);
    endtask
endmodule
`default_nettype wire

/* verif/interrupter_release_iack_chain_tb.sv */
`default_nettype none
module interrupter_release_iack_chain_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic pass;
        logic after_ds;
        logic [31:0] d;
        logic [31:0] oe;
    } note_t;
    logic core_clk, resetn, strap, reg_acc, rel_ack, irq_req, iackout_n, dtack_oe, pending;
    logic iack_n, ds0_n, ds1_n, lword_n, prev_dtack, prev_iackout;
    logic [3:1] addr;
    logic [2:0] lvl;
    logic [1:0] sw;
    logic [31:0] sid, data, data_oe, msk;
    logic [7:1] irq_oe;
    note_t note_q[$];
    int error_cnt = 0;
    int checks = 0;
    interrupter_release_iack_chain dut_u (
        .i_core_clk(core_clk),
        .i_resetn(resetn),
        .i_slot1_strap(strap),
        .i_iackin_n(iack_n),
        .i_ds0_n(ds0_n),
        .i_ds1_n(ds1_n),
        .i_lword_n(lword_n),
        .i_addr(addr),
        .o_iackout_n(iackout_n),
        .o_data(data),
        .o_data_oe(data_oe),
        .o_dtack_n(),
        .o_dtack_oe(dtack_oe),
        .o_irq_n(),
        .o_irq_oe(irq_oe),
        .i_irq_level(lvl),
        .i_status_width(sw),
        .i_release_on_acknowledge(rel_ack),
        .i_status_id(sid),
        .i_irq_request(irq_req),
        .i_reg_access(reg_acc),
        .o_pending(pending)
    );
    handler_model hm (
        .i_core_clk(core_clk),
        .i_dtack_oe(dtack_oe),
        .i_iack_first(strap),
        .o_iack_n(iack_n),
        .o_ds0_n(ds0_n),
        .o_ds1_n(ds1_n),
        .o_lword_n(lword_n),
        .o_addr(addr)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic fail(input string msg);
        error_cnt++;
        $display("ERROR %0t: %s", $time, msg);
    endtask
    task automatic chk_val(input logic [31:0] act, input logic [31:0] exp, input string what);
        checks++;
        if (act !== exp) fail($sformatf("%s got %0h want %0h", what, act, exp));
    endtask
    task automatic chk_claim();
        note_t n;
        checks++;
        if (note_q.size() == 0) fail("unexpected status answer");
        else begin
            n = note_q.pop_front();
            if (n.pass !== 1'b0 || data !== n.d || data_oe !== n.oe)
                fail($sformatf("status answer %0h/%0h want %0h/%0h", data, data_oe, n.d, n.oe));
        end
    endtask
    task automatic chk_pass();
        note_t n;
        checks++;
        if (note_q.size() == 0) fail("unexpected chain edge");
        else begin
            n = note_q.pop_front();
            if (n.pass !== 1'b1 || (n.after_ds && $time <= hm.ds_fall_t))
                fail("chain edge not expected here");
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] width_mask(input int s);
        return s == 0 ? 32'h0000_00FF : s == 1 ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    endfunction
    task automatic raise();
        @(negedge core_clk);
        irq_req = 1'b1;
        @(negedge core_clk);
        irq_req = 1'b0;
        repeat (2) @(negedge core_clk);
        chk_val({25'h0, irq_oe}, 32'h1 << (lvl - 3'h1), "request line");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        if (dtack_oe === 1'b1 && prev_dtack !== 1'b1) chk_claim();
        if (iackout_n === 1'b0 && prev_iackout !== 1'b0) chk_pass();
        prev_dtack = dtack_oe;
        prev_iackout = iackout_n;
    end
    initial begin
        #100us;
        fail("watchdog expired");
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h4F13));
        resetn = 1'b0;
        strap = 1'b0;
        reg_acc = 1'b0;
        rel_ack = 1'b1;
        irq_req = 1'b0;
        sw = 2'h0;
        sid = 32'h0;
        lvl = 3'($urandom_range(7, 1));
        repeat (20) @(negedge core_clk);
        resetn = 1'b1;
        chk_val({pending, dtack_oe, iackout_n}, 32'h1, "reset outputs");
        chk_val(data_oe | {25'h0, irq_oe}, 32'h0, "reset enables");
        // Every interrupter width against every cycle width
        for (int s = 0; s < 3; s++) begin
            for (int r = 0; r < 3; r++) begin
                sw = 2'(s);
                sid = $urandom;
                raise();
                msk = width_mask(s);
                if (r >= s) note_q.push_back({2'b00, sid & msk, msk});
                else note_q.push_back({2'b10, 64'h0});
                hm.ack_cycle(lvl, r, 2);
                chk_val({31'h0, pending}, {31'h0, r < s}, "pending after ack");
            end
        end
        // Level mismatch is forwarded
        raise();
        note_q.push_back({2'b10, 64'h0});
        hm.ack_cycle(3'((lvl % 7) + 1), 2, 2);
        chk_val({31'h0, pending}, 32'h1, "pending after mismatch");
        // Register-release mode
        rel_ack = 1'b0;
        sw = 2'h0;
        note_q.push_back({2'b00, sid & 32'h0000_00FF, 32'h0000_00FF});
        hm.ack_cycle(lvl, 0, 3);
        chk_val({25'h0, irq_oe}, 32'h1 << (lvl - 3'h1), "line after ack");
        reg_acc = 1'b1;
        repeat (10) @(negedge core_clk);
        chk_val({31'h0, pending}, 32'h1, "pending before strobe");
        hm.strobe(4);
        reg_acc = 1'b0;
        repeat (20) @(negedge core_clk);
        chk_val({pending, irq_oe}, 32'h0, "released after access");
        // Handler leaves the released line alone before its next cycle
        repeat (200) @(negedge core_clk);
        // Slot 1 chain driver, slow strobe
        strap = 1'b1;
        repeat (4) @(negedge core_clk);
        for (int k = 0; k < 2; k++) begin
            note_q.push_back({2'b11, 64'h0});
            hm.ack_cycle(lvl, 2, 8);
            chk_val({31'h0, iackout_n}, 32'h1, "chain high after ack");
        end
        chk_val(note_q.size(), 32'h0, "answers outstanding");
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* verilog/iack_chain_driver.sv */
`include "irq_cfg.svh"
`default_nettype none
module iack_chain_driver (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_iack_n,
    input wire logic i_dsa_n,
    output logic o_chain_n
);
    irq_pkg::chain_reg_t q;
    irq_pkg::chain_reg_t d;

    always_comb begin
        d = q;
        case (q.state)
            irq_pkg::CD_IDLE: begin
                if (!i_iack_n) begin
                    d.state = irq_pkg::CD_WAIT_DS;
                end
            end
            irq_pkg::CD_WAIT_DS: begin
                if (i_iack_n) begin
                    d.state = irq_pkg::CD_IDLE;
                end else if (!i_dsa_n) begin
                    d.state = irq_pkg::CD_DRIVE;
                    d.out_n = 1'b0;
                end
            end
            irq_pkg::CD_DRIVE: begin
                if (i_iack_n) begin
                    d.state = irq_pkg::CD_IDLE;
                    d.out_n = 1'b1;
                end
            end
            default: begin
                d.state = irq_pkg::CD_IDLE;
                d.out_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '{state: irq_pkg::CD_IDLE, out_n: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign o_chain_n = q.out_n;

    a_drive_after_ds: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $fell(o_chain_n) |-> $past(!i_iack_n) && $past(!i_dsa_n))
        else $error("chain edge without IACK and DSA low");
    a_edge_held: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (!i_iack_n && !i_dsa_n && q.state == irq_pkg::CD_WAIT_DS) |=> !o_chain_n)
        else $error("acknowledge cycle gave no chain edge");
    a_driver_return: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_iack_n && !o_chain_n) |=> o_chain_n)
        else $error("chain output stuck low after IACK rose");
    c_driver_edge: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
        $fell(o_chain_n));
endmodule
`default_nettype wire

/* verilog/interrupter_release_iack_chain.sv */
`include "irq_cfg.svh"
`default_nettype none
module interrupter_release_iack_chain (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Board strap: high when this board sits in the first slot
    input wire logic i_slot1_strap,
    // Backplane inputs (asynchronous)
    input wire logic i_iackin_n,
    input wire logic i_ds0_n,
    input wire logic i_ds1_n,
    input wire logic i_lword_n,
    input wire logic [3:1] i_addr,
    // Backplane outputs
    output logic o_iackout_n,
    output logic [31:0] o_data,
    output logic [31:0] o_data_oe,
    output logic o_dtack_n,
    output logic o_dtack_oe,
    output logic [7:1] o_irq_n,
    output logic [7:1] o_irq_oe,
    // On-board configuration and user side
    input wire logic [2:0] i_irq_level,
    input wire logic [1:0] i_status_width,
    input wire logic i_release_on_acknowledge,
    input wire logic [31:0] i_status_id,
    input wire logic i_irq_request,
    input wire logic i_reg_access,
    output logic o_pending
);
    localparam int REG_REL_MAX = `REG_RELEASE_CYC;
    localparam int ACK_REL_MAX = `ACK_RELEASE_CYC;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [`SY_WIDTH-1:0] pins_raw;
    logic [`SY_WIDTH-1:0] pins;

    assign pins_raw = {i_addr, i_slot1_strap, i_lword_n, i_ds1_n, i_ds0_n, i_iackin_n};

    pin_sync #(
        .WIDTH(`SY_WIDTH),
        .RESET_VAL(`SY_RESET)
    ) u_pin_sync (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_async(pins_raw),
        .o_sync(pins)
    );

    logic iackin_s;
    logic ds0_s;
    logic ds1_s;
    logic lword_s;
    logic slot1_s;
    logic [2:0] addr_s;

    assign iackin_s = pins[`SY_IACKIN];
    assign ds0_s = pins[`SY_DS0];
    assign ds1_s = pins[`SY_DS1];
    assign lword_s = pins[`SY_LWORD];
    assign slot1_s = pins[`SY_SLOT1];
    assign addr_s = pins[`SY_ADDR_HI:`SY_ADDR_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Slot-one chain driver

    logic drv_chain_n;
    logic chain_in;

    iack_chain_driver u_chain_driver (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_iack_n(iackin_s),
        .i_dsa_n(ds0_s),
        .o_chain_n(drv_chain_n)
    );

    // In slot one IACKIN carries IACK, so the driver feeds the interrupter
    assign chain_in = slot1_s ? drv_chain_n : iackin_s;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the acknowledge cycle

    irq_pkg::status_width_t cfg_width;
    irq_pkg::release_mode_t cfg_mode;
    irq_pkg::status_width_t req_width;
    logic [31:0] width_mask;
    logic width_ok;
    logic level_ok;
    logic accept;
    logic chain_fall;
    logic ds_fall;
    logic strobes_high;

    irq_pkg::intr_reg_t q;
    irq_pkg::intr_reg_t d;

    assign cfg_width = irq_pkg::status_width_t'(i_status_width);
    assign cfg_mode = irq_pkg::release_mode_t'(i_release_on_acknowledge);

    always_comb begin
        if (!lword_s && !ds1_s && !ds0_s) begin
            req_width = irq_pkg::WIDTH_WORD;
        end else if (!ds1_s && !ds0_s) begin
            req_width = irq_pkg::WIDTH_HALF;
        end else begin
            req_width = irq_pkg::WIDTH_BYTE;
        end
    end

    always_comb begin
        case (cfg_width)
            irq_pkg::WIDTH_BYTE: width_mask = `MASK_BYTE;
            irq_pkg::WIDTH_HALF: width_mask = `MASK_HALF;
            irq_pkg::WIDTH_WORD: width_mask = `MASK_WORD;
            default: width_mask = '0;
        endcase
    end

    assign width_ok = (cfg_width != irq_pkg::WIDTH_BYTE) ? (req_width >= cfg_width) : 1'b1;
    assign level_ok = (addr_s == i_irq_level);
    assign accept = q.pending && level_ok && width_ok;
    assign chain_fall = q.chain_prev && !chain_in;
    assign ds_fall = q.ds_prev && !ds0_s;
    assign strobes_high = ds0_s && ds1_s;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupter state

    always_comb begin
        d = q;
        d.ds_prev = ds0_s;
        d.chain_prev = chain_in;
        case (q.state)
            irq_pkg::ACK_IDLE: begin
                if (chain_fall) begin
                    if (accept) begin
                        d.state = irq_pkg::ACK_WAIT_DS;
                    end else begin
                        d.state = irq_pkg::ACK_PASS;
                        d.iackout_n = 1'b0;
                    end
                end
            end
            irq_pkg::ACK_PASS: begin
                if (chain_in) begin
                    d.state = irq_pkg::ACK_IDLE;
                    d.iackout_n = 1'b1;
                end
            end
            irq_pkg::ACK_WAIT_DS: begin
                if (chain_in) begin
                    d.state = irq_pkg::ACK_IDLE;
                end else if (!ds0_s) begin
                    d.state = irq_pkg::ACK_DRIVE;
                    d.data = i_status_id & width_mask;
                    d.data_oe = width_mask;
                end
            end
            irq_pkg::ACK_DRIVE: begin
                d.state = irq_pkg::ACK_DTACK;
                d.dtack_oe = 1'b1;
            end
            irq_pkg::ACK_DTACK: begin
                if (strobes_high) begin
                    d.state = irq_pkg::ACK_WAIT_END;
                    d.dtack_oe = 1'b0;
                    d.data_oe = '0;
                    if (cfg_mode == irq_pkg::REL_ACK) begin
                        d.pending = 1'b0;
                    end
                end
            end
            irq_pkg::ACK_WAIT_END: begin
                if (chain_in) begin
                    d.state = irq_pkg::ACK_IDLE;
                end
            end
            default: begin
                d.state = irq_pkg::ACK_IDLE;
                d.iackout_n = 1'b1;
                d.dtack_oe = 1'b0;
                d.data_oe = '0;
            end
        endcase

        // Register-access release, armed only by a strobe fall in that access
        if (cfg_mode == irq_pkg::REL_REGISTER) begin
            if (i_reg_access && ds_fall && q.pending) begin
                d.armed = 1'b1;
            end
            if (q.armed && strobes_high && !i_reg_access) begin
                d.pending = 1'b0;
                d.armed = 1'b0;
            end
        end else begin
            d.armed = 1'b0;
        end

        // A new request wins over a release in the same cycle
        if (i_irq_request) begin
            d.pending = 1'b1;
        end

        for (int i = `IRQ_LO; i <= `IRQ_HI; i++) begin
            d.irq_oe[i] = d.pending && (i_irq_level == 3'(i));
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '{state: irq_pkg::ACK_IDLE, pending: 1'b0, armed: 1'b0,
                   ds_prev: 1'b1, chain_prev: 1'b1, iackout_n: 1'b1,
                   dtack_oe: 1'b0, data: '0, data_oe: '0, irq_oe: '0};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_iackout_n = q.iackout_n;
    assign o_data = q.data;
    assign o_data_oe = q.data_oe;
    assign o_dtack_n = 1'b0;
    assign o_dtack_oe = q.dtack_oe;
    assign o_irq_n = '0;
    assign o_irq_oe = q.irq_oe;
    assign o_pending = q.pending;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);

    a_pass_edge: assert property (
        (q.state == irq_pkg::ACK_IDLE && chain_fall && !accept) |=> !o_iackout_n)
        else $error("unclaimed chain edge not forwarded");

    a_pass_return: assert property (
        (q.state == irq_pkg::ACK_PASS && chain_in) |=> o_iackout_n ##1 o_iackout_n)
        else $error("forwarded chain edge did not return high");

    a_data_first: assert property (
        $rose(o_dtack_oe) |-> $past(o_data_oe != '0) && (o_data_oe != '0))
        else $error("DTACK asserted before STATUS/ID was on the bus");

    a_byte_lanes: assert property (
        (o_dtack_oe && cfg_width == irq_pkg::WIDTH_BYTE) |-> o_data_oe == `MASK_BYTE)
        else $error("byte STATUS/ID drives wrong lanes");

    a_half_lanes: assert property (
        (o_dtack_oe && cfg_width == irq_pkg::WIDTH_HALF) |-> o_data_oe == `MASK_HALF)
        else $error("halfword STATUS/ID drives wrong lanes");

    a_word_only: assert property (
        ($rose(o_dtack_oe) && cfg_width == irq_pkg::WIDTH_WORD)
            |-> o_data_oe == `MASK_WORD && $past(!lword_s, 3))
        else $error("word STATUS/ID given to a narrower cycle");

    a_reply_own: assert property (
        (q.state == irq_pkg::ACK_IDLE && chain_fall && accept) |=> ##1
            (q.state == irq_pkg::ACK_WAIT_DS || q.state == irq_pkg::ACK_DRIVE
             || q.state == irq_pkg::ACK_IDLE) && o_iackout_n)
        else $error("claimed acknowledge was forwarded");

    a_reg_rel_hold: assert property (
        ($fell(o_pending) && cfg_mode == irq_pkg::REL_REGISTER) |-> $past(q.armed))
        else $error("register release before a strobe fall in the access");

    a_reg_rel_limit: assert property (
        (q.armed && strobes_high && !i_reg_access) |-> ##[1:REG_REL_MAX] !q.armed)
        else $error("register release later than allowed");

    a_ack_rel_hold: assert property (
        ($fell(o_pending) && cfg_mode == irq_pkg::REL_ACK)
            |-> $past(q.state) == irq_pkg::ACK_DTACK)
        else $error("acknowledge release outside the STATUS/ID read");

    a_ack_rel_limit: assert property (
        (q.state == irq_pkg::ACK_DTACK && strobes_high && cfg_mode == irq_pkg::REL_ACK
         && !i_irq_request) |-> ##[1:ACK_REL_MAX] !o_pending)
        else $error("acknowledge release later than allowed");

    a_one_line: assert property (
        (o_irq_oe != '0) |-> $onehot(o_irq_oe) && o_pending)
        else $error("request on more than one line");

    c_pass: cover property ((q.state == irq_pkg::ACK_PASS) ##[1:20] o_iackout_n);
    c_byte_reply: cover property ($rose(o_dtack_oe) && cfg_width == irq_pkg::WIDTH_BYTE);
    c_reg_release: cover property ($fell(o_pending) && cfg_mode == irq_pkg::REL_REGISTER);
    c_ack_release: cover property ($fell(o_pending) && cfg_mode == irq_pkg::REL_ACK);
endmodule
`default_nettype wire

/* verilog/pin_sync.sv */
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_reg_t;

    sync_reg_t q;
    sync_reg_t d;

    // First stage feeds only the second stage
    always_comb begin
        d.first = i_async;
        d.second = q.first;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= {RESET_VAL, RESET_VAL};
        end else begin
            q <= d;
        end
    end

    assign o_sync = q.second;
endmodule
`default_nettype wire
